// ===== pkg/pmcr_pkg.sv
// pmcr_pkg: offsets, field positions, reset values, timing and types of the
// phy miscellaneous control register bank.
// assumes a 20 MHz pclk and a 32-bit apb register bus.
package pmcr_pkg;
  // register indices and their apb byte addresses (index times four)
  localparam logic [7:0]  IDX_MISC_CONFIG = 8'h1e;            // phy_misc_config
  localparam logic [7:0]  IDX_SOFT_RESET  = 8'h1f;            // phy_soft_reset_control
  localparam logic [7:0]  IDX_TEST_CHAN   = 8'h25;            // test_channel_select
  localparam logic [7:0]  IDX_IRQ_STATUS  = 8'h26;            // interrupt status, w1c
  localparam logic [7:0]  IDX_IRQ_MASK    = 8'h27;            // interrupt mask
  localparam logic [11:0] ADDR_MISC_CONFIG = {2'h0, IDX_MISC_CONFIG, 2'h0};
  localparam logic [11:0] ADDR_SOFT_RESET  = {2'h0, IDX_SOFT_RESET, 2'h0};
  localparam logic [11:0] ADDR_TEST_CHAN   = {2'h0, IDX_TEST_CHAN, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STATUS  = {2'h0, IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] ADDR_IRQ_MASK    = {2'h0, IDX_IRQ_MASK, 2'h0};
  // phy_misc_config field positions
  localparam int MC_FFD_BIT    = 11;                          // forced_full_duplex_override
  localparam int MC_ROBUST_BIT = 9;                           // deadlock_free_crossover_resolve
  localparam int MC_QUICK_BIT  = 8;                           // quick_crossover_resolve
  localparam int MC_PADDIR_BIT = 7;                           // pad is interrupt output
  localparam int MC_FORCE_BIT  = 6;                           // force interrupt
  localparam int MC_FAIL_BIT   = 2;                           // cable_test_failed
  localparam int MC_DONE_BIT   = 1;                           // cable_test_complete
  localparam int MC_LAUNCH_BIT = 0;                           // cable_test_launch
  // phy_soft_reset_control and test_channel_select field positions
  localparam int SR_FULL_BIT    = 15;                         // full_soft_reset
  localparam int SR_RESTART_BIT = 14;                         // soft_restart_keep_config
  localparam int TC_SEL_LSB     = 5;                          // test_pattern_lane_select lsb
  localparam int TC_HI_LSB      = 8;                          // fixed upper byte lsb
  localparam logic [7:0] TC_HI_VAL = 8'h04;                   // fixed upper byte value
  // interrupt status bit positions
  localparam int IRQ_DONE_BIT = 0;                            // cable test finished
  localparam int IRQ_FAIL_BIT = 1;                            // cable test failed
  localparam int IRQ_EXT_BIT  = 2;                            // external phy event
  // reset values
  localparam logic       RST_DONE = 1'b1;                     // completion flag
  localparam logic [2:0] RST_SEL  = 3'h0;                     // lane select
  localparam logic [2:0] RST_IRQ  = 3'h0;                     // status and mask
  // reset hold times
  localparam int CLK_PERIOD_NS  = 50;                         // pclk period
  localparam int FULL_RESET_NS  = 1000;                       // core reset hold
  localparam int RESTART_NS     = 1000;                       // core restart hold
  localparam logic [7:0] FULL_RESET_CYC =
    8'((FULL_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RESTART_CYC =
    8'((RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // types
  typedef enum logic {HOLD_IDLE = 1'b0, HOLD_RUN = 1'b1} pmcr_hold_fsm_type;
  typedef enum logic [1:0] {LANE_A = 2'b00, LANE_B = 2'b01,
                            LANE_C = 2'b10, LANE_D = 2'b11} pmcr_lane_type;
  typedef struct packed {
    logic       ffd;                                          // duplex override
    logic       robust;                                       // robust crossover
    logic       quick;                                        // quick crossover
    logic       pad_dir;                                      // 1 = interrupt out
    logic       force_irq;                                    // forced interrupt
    logic       fail;                                         // cable test failed
    logic       done;                                         // cable test complete
    logic       launch;                                       // cable test launch
    logic [2:0] tc_sel;                                       // lane select field
    logic [2:0] irq_status;                                   // sticky events
    logic [2:0] irq_mask;                                     // event enables
  } pmcr_cfg_type;
  localparam pmcr_cfg_type CFG_RST = '{done: RST_DONE, tc_sel: RST_SEL,
    irq_status: RST_IRQ, irq_mask: RST_IRQ, default: 1'b0};
endpackage

// ===== pkg/pmcr_lane_if.sv
// pmcr_lane_if: lane select field out to the decoder, lane enables back.
// assumes both ends run on pclk.
`timescale 1ns/1ps
interface pmcr_lane_if;
  logic [2:0] sel;                                            // test_pattern_lane_select
  logic [3:0] lane_en;                                        // bit0 = a .. bit3 = d
  modport ctrl (output sel, input lane_en);
  modport dec  (input sel, output lane_en);
endinterface

// ===== rtl/pmcr_pulse_hold.sv
// pmcr_pulse_hold: turns a one-cycle start into a busy level of fixed length.
// assumes start is a pclk-synchronous pulse; starts while busy are ignored.
`timescale 1ns/1ps
module pmcr_pulse_hold #(
  parameter logic [7:0] HOLD_CYC = 8'h01                      // busy length in cycles
) (
  input  wire logic pclk,                                     // apb clock
  input  wire logic presetn,                                  // async reset, low
  input  wire logic start,                                    // launch pulse
  output logic      busy                                      // held level
);
  import pmcr_pkg::*;
  typedef struct packed {
    pmcr_hold_fsm_type fsm;                                   // idle or running
    logic [7:0]        cnt;                                   // cycles left
    logic              busy;                                  // output flop
  } pmcr_hold_type;
  pmcr_hold_type st_ff;                                       // registered state
  pmcr_hold_type nxt_st;                                      // next state
  // count busy cycles down to zero
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff.fsm)
      HOLD_IDLE: begin
        if (start) begin
          nxt_st.fsm  = HOLD_RUN;
          nxt_st.cnt  = HOLD_CYC - 8'h01;
          nxt_st.busy = 1'b1;
        end
      end
      HOLD_RUN: begin
        if (st_ff.cnt == 8'h00) begin
          nxt_st.fsm  = HOLD_IDLE;
          nxt_st.busy = 1'b0;
        end else begin
          nxt_st.cnt = st_ff.cnt - 8'h01;
        end
      end
    endcase
  end
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{fsm: HOLD_IDLE, cnt: 8'h00, busy: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign busy = st_ff.busy;
endmodule // pmcr_pulse_hold

// ===== rtl/pmcr_lane_decode.sv
// pmcr_lane_decode: registered decode of the test lane select field.
// assumes the select field comes from the register bank on pclk.
`timescale 1ns/1ps
module pmcr_lane_decode (
  input  wire logic  pclk,                                    // apb clock
  input  wire logic  presetn,                                 // async reset, low
  pmcr_lane_if.dec   lane                                     // select in, enables out
);
  import pmcr_pkg::*;
  typedef struct packed {
    logic [3:0] lane_en;                                      // one bit per pair
  } pmcr_dec_type;
  pmcr_dec_type  st_ff;                                       // registered state
  pmcr_dec_type  nxt_st;                                      // next state
  pmcr_lane_type pick;                                        // single lane choice
  // top bit drives all pairs, else one pair by the low bits
  always_comb begin
    nxt_st = st_ff;
    pick   = pmcr_lane_type'(lane.sel[1:0]);
    if (lane.sel[2]) begin
      nxt_st.lane_en = 4'hf;
    end else begin
      unique case (pick)
        LANE_A: nxt_st.lane_en = 4'h1;
        LANE_B: nxt_st.lane_en = 4'h2;
        LANE_C: nxt_st.lane_en = 4'h4;
        LANE_D: nxt_st.lane_en = 4'h8;
      endcase
    end
  end
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{lane_en: 4'h1};
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign lane.lane_en = st_ff.lane_en;
endmodule // pmcr_lane_decode

// ===== rtl/pmcr_phy_misc_regs.sv
// pmcr_phy_misc_regs: apb register bank for phy duplex, crossover, pad,
// cable test, soft reset and test lane controls, with an interrupt block.
// assumes a zero-wait capable apb master, a cable test engine that pulses
// when a measurement ends, and a phy core that honours the reset holds.
//
// Overview of operation
// - duplex override forces full with forced-100 partner
// - robust bit selects deadlock-free crossover resolution
// - quick bit selects shortened crossover resolution
// - pad direction: 1 interrupt out, 0 powerdown in
// - force bit asserts interrupt pin unconditionally
// - reserved bits ignore writes, read zero
// - launch starts test; complete reads 0 while running
// - failed flag shows a failed test, resets 0
// - full reset resets everything, bit self-clears
// - restart resets core, keeps registers, self-clears
// - select top bit drives all four pairs
// - otherwise low bits pick pair a to d
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module pmcr_phy_misc_regs (
  input  wire logic        pclk,                              // apb clock, 20 MHz
  input  wire logic        presetn,                           // async reset, low
  input  wire logic        psel,                              // apb select
  input  wire logic        penable,                           // apb access phase
  input  wire logic        pwrite,                            // apb write
  input  wire logic [11:0] paddr,                             // apb byte address
  input  wire logic [31:0] pwdata,                            // apb write data
  output logic      [31:0] prdata,                            // apb read data
  output logic             pready,                            // apb ready
  output logic             pslverr,                           // apb error
  input  wire logic        lp_forced_100,                     // partner forced 100
  input  wire logic        ieee_duplex_full,                  // standard resolution
  output logic             duplex_full,                       // resolved duplex
  output logic             deadlock_free_crossover_resolve,   // robust mode
  output logic             quick_crossover_resolve,           // quick mode
  input  wire logic        irq_or_powerdown_pad_i,            // pad level in
  output logic             irq_or_powerdown_pad_o,            // pad level out
  output logic             irq_or_powerdown_pad_oe,           // pad drive enable
  output logic             powerdown_req,                     // pad powerdown
  input  wire logic        phy_event,                         // external event pulse
  output logic             irq,                               // interrupt, high
  output logic             cable_test_launch_pulse,           // start engine
  input  wire logic        cable_test_finished,               // engine end pulse
  input  wire logic        cable_test_bad,                    // result with end
  output logic             core_reset_hold,                   // full core reset
  output logic             core_restart_hold,                 // restart, regs kept
  output logic      [3:0]  test_lane_en                       // pairs a..d
);
  import pmcr_pkg::*;

  // whole state of the bank
  typedef struct packed {
    pmcr_cfg_type cfg;                                        // software fields
    logic         full_busy_q;                                // delayed reset busy
    logic         launch_pulse;                               // engine start
    logic         pready;                                     // apb ready
    logic         pslverr;                                    // apb error
    logic [31:0]  prdata;                                     // apb read data
    logic         irq;                                        // interrupt level
    logic         pad_o;                                      // pad out level
    logic         pad_oe;                                     // pad enable
    logic         powerdown;                                  // powerdown request
    logic         duplex_full;                                // resolved duplex
  } pmcr_state_type;

  localparam pmcr_state_type STATE_RST = '{cfg: CFG_RST, pad_o: 1'b1,
    prdata: 32'h0000_0000, default: 1'b0};

  pmcr_state_type st_ff;                                      // registered state
  pmcr_state_type nxt_st;                                     // next state

  logic          full_busy;                                   // full reset running
  logic          restart_busy;                                // restart running
  logic          full_start;                                  // full reset write
  logic          restart_start;                               // restart write
  logic          setup;                                       // apb setup phase
  logic          wr_en;                                       // write commits
  logic          hit_misc;                                    // decode misc
  logic          hit_ctrl;                                    // decode control
  logic          hit_tc;                                      // decode test chan
  logic          hit_ists;                                    // decode status
  logic          hit_imsk;                                    // decode mask
  logic          mapped;                                      // any hit
  logic [15:0]   rd_misc;                                     // misc read view
  logic [15:0]   rd_ctrl;                                     // control read view
  logic [15:0]   rd_tc;                                       // test chan view
  logic [2:0]    irq_set;                                     // events this cycle
  logic [2:0]    irq_clr;                                     // w1c this cycle
  logic          in_test;                                     // measurement running
  logic          test_end;                                    // accepted end pulse
  logic          irq_nxt;                                     // next interrupt level

  pmcr_lane_if   lane_bus ();                                 // to lane decoder

  // address decode, exact aligned byte addresses only
  always_comb begin
    hit_misc = (paddr == ADDR_MISC_CONFIG);
    hit_ctrl = (paddr == ADDR_SOFT_RESET);
    hit_tc   = (paddr == ADDR_TEST_CHAN);
    hit_ists = (paddr == ADDR_IRQ_STATUS);
    hit_imsk = (paddr == ADDR_IRQ_MASK);
    mapped   = hit_misc | hit_ctrl | hit_tc | hit_ists | hit_imsk;
  end

  // apb phases: answer is registered in setup, commit on the ready edge
  always_comb begin
    setup = psel & ~penable;
    wr_en = psel & penable & pwrite & st_ff.pready & ~st_ff.pslverr;
  end

  // self-clearing control writes start the hold timers
  always_comb begin
    full_start    = wr_en & hit_ctrl & pwdata[SR_FULL_BIT];
    restart_start = wr_en & hit_ctrl & pwdata[SR_RESTART_BIT];
  end

  // full reset hold timer, also read back as the bit itself
  pmcr_pulse_hold #(
    .HOLD_CYC (FULL_RESET_CYC)
  ) u_full_hold (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (full_start),
    .busy    (full_busy)
  );

  // restart hold timer, registers untouched
  pmcr_pulse_hold #(
    .HOLD_CYC (RESTART_CYC)
  ) u_restart_hold (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (restart_start),
    .busy    (restart_busy)
  );

  // lane select goes out over the carrier interface
  assign lane_bus.sel = st_ff.cfg.tc_sel;

  pmcr_lane_decode u_lane_decode (
    .pclk    (pclk),
    .presetn (presetn),
    .lane    (lane_bus.ctrl)
  );

  // read views; reserved bits are tied to zero
  always_comb begin
    rd_misc                = 16'h0000;
    rd_misc[MC_FFD_BIT]    = st_ff.cfg.ffd;
    rd_misc[MC_ROBUST_BIT] = st_ff.cfg.robust;
    rd_misc[MC_QUICK_BIT]  = st_ff.cfg.quick;
    rd_misc[MC_PADDIR_BIT] = st_ff.cfg.pad_dir;
    rd_misc[MC_FORCE_BIT]  = st_ff.cfg.force_irq;
    rd_misc[MC_FAIL_BIT]   = st_ff.cfg.fail;
    rd_misc[MC_DONE_BIT]   = st_ff.cfg.done;
    rd_misc[MC_LAUNCH_BIT] = st_ff.cfg.launch;
    rd_ctrl                 = 16'h0000;
    rd_ctrl[SR_FULL_BIT]    = full_busy;
    rd_ctrl[SR_RESTART_BIT] = restart_busy;
    rd_tc                           = 16'h0000;
    rd_tc[TC_HI_LSB +: 8]           = TC_HI_VAL;
    rd_tc[TC_SEL_LSB +: 3]          = st_ff.cfg.tc_sel;
  end

  // cable test progress and interrupt event collection
  always_comb begin
    in_test  = ~st_ff.cfg.done;
    test_end = in_test & cable_test_finished;
    irq_set               = 3'h0;
    irq_set[IRQ_DONE_BIT] = test_end;
    irq_set[IRQ_FAIL_BIT] = test_end & cable_test_bad;
    irq_set[IRQ_EXT_BIT]  = phy_event;
    irq_clr = (wr_en & hit_ists) ? pwdata[2:0] : 3'h0;
  end

  // next state of the whole bank
  always_comb begin
    nxt_st = st_ff;
    nxt_st.launch_pulse = 1'b0;
    nxt_st.full_busy_q  = full_busy;

    // apb answer registered during setup, dropped after the access edge
    nxt_st.pready  = setup;
    nxt_st.pslverr = setup & ~mapped;
    nxt_st.prdata  = 32'h0000_0000;
    if (setup & ~pwrite) begin
      unique case (1'b1)
        hit_misc: nxt_st.prdata = {16'h0000, rd_misc};
        hit_ctrl: nxt_st.prdata = {16'h0000, rd_ctrl};
        hit_tc:   nxt_st.prdata = {16'h0000, rd_tc};
        hit_ists: nxt_st.prdata = {29'h0, st_ff.cfg.irq_status};
        hit_imsk: nxt_st.prdata = {29'h0, st_ff.cfg.irq_mask};
        default:  nxt_st.prdata = 32'h0000_0000;              // unmapped
      endcase
    end

    // configuration writes; only the defined fields are stored
    if (wr_en & hit_misc) begin
      nxt_st.cfg.ffd       = pwdata[MC_FFD_BIT];
      nxt_st.cfg.robust    = pwdata[MC_ROBUST_BIT];
      nxt_st.cfg.quick     = pwdata[MC_QUICK_BIT];
      nxt_st.cfg.pad_dir   = pwdata[MC_PADDIR_BIT];
      nxt_st.cfg.force_irq = pwdata[MC_FORCE_BIT];
      nxt_st.cfg.launch    = pwdata[MC_LAUNCH_BIT];
      // a new measurement only starts when none is running
      if (pwdata[MC_LAUNCH_BIT] & st_ff.cfg.done) begin
        nxt_st.cfg.done     = 1'b0;
        nxt_st.cfg.fail     = 1'b0;
        nxt_st.launch_pulse = 1'b1;
      end else if (pwdata[MC_LAUNCH_BIT]) begin
        nxt_st.cfg.launch = 1'b1;                             // still running
      end
    end
    if (wr_en & hit_tc) begin
      nxt_st.cfg.tc_sel = pwdata[TC_SEL_LSB +: 3];
    end
    if (wr_en & hit_imsk) begin
      nxt_st.cfg.irq_mask = pwdata[2:0];
    end

    // end of measurement: flags settle, launch bit clears
    if (test_end) begin
      nxt_st.cfg.done   = 1'b1;
      nxt_st.cfg.fail   = cable_test_bad;
      nxt_st.cfg.launch = 1'b0;
    end

    // sticky status: a new event wins over a same-cycle clear
    nxt_st.cfg.irq_status = (st_ff.cfg.irq_status & ~irq_clr) | irq_set;

    // full soft reset: at the end of the hold every field returns to reset
    if (st_ff.full_busy_q & ~full_busy) begin
      nxt_st.cfg = CFG_RST;
    end

    // interrupt level, pad and powerdown
    irq_nxt = (|(nxt_st.cfg.irq_status & nxt_st.cfg.irq_mask))
              | nxt_st.cfg.force_irq;
    nxt_st.irq    = irq_nxt;
    nxt_st.pad_oe = nxt_st.cfg.pad_dir;
    nxt_st.pad_o  = ~irq_nxt;                                 // active-low pad
    nxt_st.powerdown = ~nxt_st.cfg.pad_dir & ~irq_or_powerdown_pad_i;

    // duplex resolution with forced-100 partner override
    if (nxt_st.cfg.ffd & lp_forced_100) begin
      nxt_st.duplex_full = 1'b1;
    end else begin
      nxt_st.duplex_full = ieee_duplex_full;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  assign prdata                          = st_ff.prdata;
  assign pready                          = st_ff.pready;
  assign pslverr                         = st_ff.pslverr;
  assign duplex_full                     = st_ff.duplex_full;
  assign deadlock_free_crossover_resolve = st_ff.cfg.robust;
  assign quick_crossover_resolve         = st_ff.cfg.quick;
  assign irq_or_powerdown_pad_o          = st_ff.pad_o;
  assign irq_or_powerdown_pad_oe         = st_ff.pad_oe;
  assign powerdown_req                   = st_ff.powerdown;
  assign irq                             = st_ff.irq;
  assign cable_test_launch_pulse         = st_ff.launch_pulse;
  assign core_reset_hold                 = full_busy;
  assign core_restart_hold               = restart_busy;
  assign test_lane_en                    = lane_bus.lane_en;
endmodule // pmcr_phy_misc_regs

// ===== tb/pmcr_phy_misc_regs_properties.sv
// pmcr_phy_misc_regs_props: port checks of the phy misc register bank.
// assumes one pclk domain; bound to the bank below.
`timescale 1ns/1ps
module pmcr_phy_misc_regs_props (
  input wire logic        pclk, presetn, psel, penable, pready, pslverr, irq,
  input wire logic        irq_or_powerdown_pad_o, irq_or_powerdown_pad_oe,
  input wire logic        cable_test_launch_pulse, core_reset_hold, core_restart_hold,
  input wire logic [31:0] prdata,
  input wire logic [3:0]  test_lane_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_hold(h); ##19 h ##1 !h; endsequence // up 20 cycles, then down
  a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready) else $error("ready");
  a_err_ready: assert property (pslverr |-> pready) else $error("slverr");
  a_rdata_idle:
    assert property (!pready |-> prdata == 32'h0) else $error("rdata");
  a_pad_irq:
    assert property (irq_or_powerdown_pad_oe |-> irq_or_powerdown_pad_o == !irq) else $error("pad");
  a_launch_once:
    assert property (cable_test_launch_pulse |=> !cable_test_launch_pulse) else $error("launch");
  a_lane_code:
    assert property ($onehot(test_lane_en) || test_lane_en == 4'hf) else $error("lane");
  a_full_hold:
    assert property ($rose(core_reset_hold) |-> s_hold(core_reset_hold)) else $error("full");
  a_restart_hold:
    assert property ($rose(core_restart_hold) |-> s_hold(core_restart_hold)) else $error("rst");
endmodule // pmcr_phy_misc_regs_props
bind pmcr_phy_misc_regs pmcr_phy_misc_regs_props i_pmcr_phy_misc_regs_props (.pclk, .presetn,
  .psel, .penable, .pready, .pslverr, .irq, .irq_or_powerdown_pad_o, .irq_or_powerdown_pad_oe,
  .cable_test_launch_pulse, .core_reset_hold, .core_restart_hold, .prdata, .test_lane_en);

// ===== tb/phy_misc_control_regs_tb_top.sv
// phy_misc_control_regs_tb_top: apb bench of the phy misc register bank.
// assumes pmcr_pkg and the bound checker are compiled first.
`timescale 1ns/1ps
module phy_misc_control_regs_tb_top;
  import pmcr_pkg::*;
  `define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, x); end end
  typedef struct {logic [11:0] a; logic [31:0] d, r; logic [3:0] l;} pmcr_row_type;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lp_forced_100 = 0, e;
  logic ieee_duplex_full = 0, irq_or_powerdown_pad_i = 1, phy_event = 0, cable_test_bad = 0;
  logic cable_test_finished = 0, pready, pslverr, duplex_full, deadlock_free_crossover_resolve;
  logic quick_crossover_resolve, irq_or_powerdown_pad_o, irq_or_powerdown_pad_oe, irq;
  logic powerdown_req, cable_test_launch_pulse, core_reset_hold, core_restart_hold;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic [3:0]  test_lane_en;
  int          n_mismatch = 0, num_checks = 0;
  // address, write data, read back, lane enables
  pmcr_row_type rows[8] = '{'{ADDR_MISC_CONFIG, 32'hfffffffe, 32'hbc2, 4'h1},
    '{ADDR_SOFT_RESET, 32'h3fff, 32'h0, 4'h1}, '{ADDR_TEST_CHAN, 32'hffffffff, 32'h4e0, 4'hf},
    '{ADDR_TEST_CHAN, 32'h20, 32'h420, 4'h2}, '{ADDR_TEST_CHAN, 32'h40, 32'h440, 4'h4},
    '{ADDR_TEST_CHAN, 32'h60, 32'h460, 4'h8}, '{ADDR_TEST_CHAN, 32'h0, 32'h400, 4'h1},
    '{ADDR_IRQ_MASK, 32'hffffffff, 32'h7, 4'h1}};
  always #25 pclk = ~pclk;
  pmcr_phy_misc_regs i_pmcr_phy_misc_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .lp_forced_100, .ieee_duplex_full, .duplex_full,
    .deadlock_free_crossover_resolve, .quick_crossover_resolve, .irq_or_powerdown_pad_i,
    .irq_or_powerdown_pad_o, .irq_or_powerdown_pad_oe, .powerdown_req, .phy_event, .irq,
    .cable_test_launch_pulse, .cable_test_finished, .cable_test_bad, .core_reset_hold,
    .core_restart_hold, .test_lane_en);
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata; e = pslverr; {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(a, 1'b0, 32'h0); `CHK(r, x)
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin #(50 * 4000); n_mismatch++; conclude; end // hang cut
  initial begin
    repeat (12) @(posedge pclk);
    `CHK({irq_or_powerdown_pad_o, irq_or_powerdown_pad_oe, test_lane_en}, 6'h21)
    presetn <= 1'b1;
    rd(ADDR_MISC_CONFIG, 32'h2);
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b1, rows[i].d); rd(rows[i].a, rows[i].r);
      `CHK(test_lane_en, rows[i].l)
    end
    irq_or_powerdown_pad_i <= 1'b0; apb(ADDR_MISC_CONFIG, 1'b1, 32'h0);
    @(posedge pclk) `CHK(powerdown_req, 1'b1)
    apb(ADDR_MISC_CONFIG, 1'b1, 32'hbc0); lp_forced_100 <= 1'b1; repeat (3) @(posedge pclk);
    `CHK({duplex_full, deadlock_free_crossover_resolve, quick_crossover_resolve}, 3'h7)
    `CHK({irq, irq_or_powerdown_pad_oe, irq_or_powerdown_pad_o, powerdown_req}, 4'hc)
    apb(ADDR_MISC_CONFIG, 1'b1, 32'h1);
    @(posedge pclk) `CHK(cable_test_launch_pulse, 1'b1)
    rd(ADDR_MISC_CONFIG, 32'h1);
    `CHK({duplex_full, irq}, 2'h0)
    {cable_test_finished, cable_test_bad} <= 2'b11; @(posedge pclk) cable_test_finished <= 1'b0;
    rd(ADDR_MISC_CONFIG, 32'h6); rd(ADDR_IRQ_STATUS, 32'h3);
    `CHK(irq, 1'b1)
    apb(ADDR_IRQ_STATUS, 1'b1, 32'h7); rd(ADDR_IRQ_STATUS, 32'h0); `CHK(irq, 1'b0)
    phy_event <= 1'b1; @(posedge pclk) phy_event <= 1'b0; rd(ADDR_IRQ_STATUS, 32'h4);
    `CHK(irq, 1'b1)
    apb(ADDR_IRQ_MASK, 1'b1, 32'h0); apb(12'h0a0, 1'b0, 32'h0); `CHK({e, irq}, 2'h2)
    apb(ADDR_IRQ_MASK, 1'b1, 32'h5); apb(ADDR_SOFT_RESET, 1'b1, 32'h4000);
    @(posedge pclk) `CHK({core_reset_hold, core_restart_hold}, 2'h1)
    repeat (25) @(posedge pclk); rd(ADDR_IRQ_MASK, 32'h5); rd(ADDR_SOFT_RESET, 32'h0);
    apb(ADDR_SOFT_RESET, 1'b1, 32'h8000); rd(ADDR_SOFT_RESET, 32'h8000);
    `CHK({core_reset_hold, core_restart_hold}, 2'h2)
    repeat (25) @(posedge pclk); rd(ADDR_IRQ_MASK, 32'h0); rd(ADDR_SOFT_RESET, 32'h0);
    conclude;
  end
endmodule // phy_misc_control_regs_tb_top
